// ===== shared/kwu_pkg.sv
`default_nettype none
package kwu_pkg;
    // Register byte positions, all bit fields and the bus width
    localparam int KWU_NPOS = 8;
    localparam int KWU_NIMPL = 4;
    localparam int KWU_AW = 12;
    localparam logic [KWU_AW-1:0] KWU_OFF_SC = 12'h000;
    localparam logic [KWU_AW-1:0] KWU_OFF_PE = 12'h004;
    localparam logic [KWU_AW-1:0] KWU_OFF_ES = 12'h008;
    localparam int KWU_SC_MODE = 0;
    localparam int KWU_SC_IE = 1;
    localparam int KWU_SC_ACK = 2;
    localparam int KWU_SC_FLAG = 3;
    localparam logic KWU_RST_MODE = 1'b0;
    localparam logic KWU_RST_IE = 1'b0;
    localparam logic KWU_RST_FLAG = 1'b0;
    localparam logic [KWU_NPOS-1:0] KWU_RST_PE = 8'h00;
    localparam logic [KWU_NPOS-1:0] KWU_RST_ES = 8'h00;

    typedef enum logic [0:0] {
        KWU_APB_IDLE = 1'b0,
        KWU_APB_ACC = 1'b1
    } kwu_apb_state_t;
endpackage : kwu_pkg
`default_nettype wire

// ===== rtl/kwu_pin_sync.sv
`timescale 1ns/1ps
`default_nettype none
module kwu_pin_sync #(
    parameter int WIDTH = 4
) (
    input wire logic pclk, // Bus clock
    input wire logic rst_n, // Async reset, active low
    input wire logic [WIDTH-1:0] async_in, // Unsynchronised inputs
    output logic [WIDTH-1:0] sync_out // Filtered, synchronised
);
    logic [WIDTH-1:0] s1_ff;
    logic [WIDTH-1:0] s2_ff;
    logic [WIDTH-1:0] s3_ff;
    logic [WIDTH-1:0] filt_ff;
    logic [WIDTH-1:0] nxt_filt;

    // A change is taken only once stages two and three agree
    assign nxt_filt = (s2_ff & s3_ff) | (filt_ff & (s2_ff | s3_ff));
    assign sync_out = filt_ff;

    always_ff @(posedge pclk or negedge rst_n) begin
        if (!rst_n) begin
            s1_ff <= '0;
            s2_ff <= '0;
            s3_ff <= '0;
            filt_ff <= '0;
        end else begin
            s1_ff <= async_in;
            s2_ff <= s1_ff;
            s3_ff <= s2_ff;
            filt_ff <= nxt_filt;
        end
    end
endmodule : kwu_pin_sync
`default_nettype wire

// ===== rtl/kwu_wake_latch.sv
`timescale 1ns/1ps
`default_nettype none
module kwu_wake_latch (
    input wire logic hit, // Async pin hit, no clock needed
    input wire logic clr_n, // Async clear, active low
    output logic wake_ff // Sticky wake request
);
    // Runs with the bus clock stopped; a glitch on hit wakes early and also sets the event flag
    always_ff @(posedge hit or negedge clr_n) begin
        if (!clr_n) begin
            wake_ff <= 1'b0;
        end else begin
            wake_ff <= 1'b1;
        end
    end
endmodule : kwu_wake_latch
`default_nettype wire

// ===== rtl/kwu_top.sv
// The register offsets and the APB register port are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
// What this block does
// [RQ1] Per-pin enable bits in pin enable register
// [RQ2] Only lowest four input positions have pins
// [RQ3] Edge select bit picks pin polarity
// [RQ4] Status bit 0 selects edge or edge-level
// [RQ5] Edges found on bus clock samples
// [RQ6] No edge until all enabled pins deassert
// [RQ7] Valid edge sets the event flag
// [RQ8] Level mode: asserted level sets flag too
// [RQ9] Request only when flag and enable set
// [RQ10] Acknowledge write clears flag, reads zero
// [RQ11] Level mode: asserted pin keeps flag set
// [RQ12] Direct writes to flag are ignored
// [RQ13] Status bits 7 to 4 read zero
// [RQ14] Keeps detecting in wait mode
// [RQ15] Asynchronous wake detection in third stop mode
// [RQ16] Held in reset in first two stops
// [RQ17] Normal operation in background debug
// [RQ18] Pull direction follows polarity bit
// [RQ19] Software follows safe setup order
// [RQ20] Reset clears all control and flag
module kwu_top #(
    parameter int NUM_PINS = kwu_pkg::KWU_NIMPL
) (
    input wire logic pclk, // Bus clock, 40 MHz
    input wire logic presetn, // Async reset, active low
    input wire logic psel, // APB select
    input wire logic penable, // APB enable
    input wire logic pwrite, // APB direction
    input wire logic [kwu_pkg::KWU_AW-1:0] paddr, // APB byte address
    input wire logic [31:0] pwdata, // APB write data
    input wire logic [3:0] pstrb, // APB byte strobes
    output logic [31:0] prdata, // APB read data
    output logic pready, // APB ready
    output logic pslverr, // APB error, unmapped address
    input wire logic [NUM_PINS-1:0] key_input_pin, // Keyboard pins
    input wire logic [NUM_PINS-1:0] port_pull_enable, // Port pull enables
    input wire logic stop3_mode, // Third stop mode active
    input wire logic stop12_mode, // First or second stop active
    output logic key_irq, // Interrupt request, active high
    output logic wake_req, // Stop wake request, active high
    output logic [NUM_PINS-1:0] pin_pullup, // Pullup select
    output logic [NUM_PINS-1:0] pin_pulldown // Pulldown select
);
    import kwu_pkg::*;

    localparam int NP = KWU_NPOS;

    logic rst_n;
    logic [NP-1:0] en_ff;
    logic [NP-1:0] nxt_en;
    logic [NP-1:0] pol_ff;
    logic [NP-1:0] nxt_pol;
    logic mode_ff;
    logic nxt_mode;
    logic ie_ff;
    logic nxt_ie;
    logic flag_ff;
    logic nxt_flag;
    logic armed_ff;
    logic irq_ff;
    logic wake_taken_ff;
    kwu_apb_state_t state_ff;
    kwu_apb_state_t nxt_state;
    logic pready_ff;
    logic pslverr_ff;
    logic [31:0] prdata_ff;
    logic [31:0] nxt_prdata;
    logic [NUM_PINS-1:0] pullup_ff;
    logic [NUM_PINS-1:0] pulldown_ff;

    logic [NUM_PINS-1:0] pin_filt;
    logic [NP-1:0] lvl_asserted;
    logic [NP-1:0] raw_hit;
    logic any_asserted;
    logic edge_hit;
    logic level_hit;
    logic wake_sync;
    logic wake_set;
    logic wake_hit;
    logic wake_clr_n;
    logic flag_set;
    logic setup;
    logic acc;
    logic hit_sc;
    logic hit_pe;
    logic hit_es;
    logic mapped;
    logic wr_ok;
    logic wr_sc;
    logic ack;
    logic [7:0] sc_read;
    logic [7:0] rd_byte;

    // First and second stop hold the unit in reset; leaving them restarts it
    assign rst_n = presetn & ~stop12_mode; // [RQ16]

    kwu_pin_sync #(
        .WIDTH(NUM_PINS)
    ) u_pin_sync (
        .pclk(pclk),
        .rst_n(rst_n),
        .async_in(key_input_pin),
        .sync_out(pin_filt)
    );

    genvar gi;
    generate
        for (gi = 0; gi < NP; gi = gi + 1) begin : g_pos
            if (gi < NUM_PINS) begin : g_pin
                // Asserted when the level matches the polarity bit
                assign lvl_asserted[gi] = en_ff[gi] & ~(pin_filt[gi] ^ pol_ff[gi]); // [RQ1] [RQ3]
                assign raw_hit[gi] = en_ff[gi] & ~(key_input_pin[gi] ^ pol_ff[gi]); // [RQ15]
            end else begin : g_none
                // No pin behind this position
                assign lvl_asserted[gi] = 1'b0; // [RQ2]
                assign raw_hit[gi] = 1'b0; // [RQ2]
            end
        end
    endgenerate

    assign any_asserted = |lvl_asserted;
    // Armed means all enabled pins sat deasserted on the previous sample
    assign edge_hit = armed_ff & any_asserted; // [RQ5] [RQ6]
    assign level_hit = mode_ff & any_asserted; // [RQ4] [RQ8]

    // Stop3 path: no clock, so raw pins feed the latch directly
    assign wake_hit = stop3_mode & ie_ff & (|raw_hit); // [RQ15]
    assign wake_clr_n = rst_n & ~wake_taken_ff;

    kwu_wake_latch u_wake_latch (
        .hit(wake_hit),
        .clr_n(wake_clr_n),
        .wake_ff(wake_req)
    );

    kwu_pin_sync #(
        .WIDTH(1)
    ) u_wake_sync (
        .pclk(pclk),
        .rst_n(rst_n),
        .async_in(wake_req),
        .sync_out(wake_sync)
    );

    // Edges missed while the clock slept are recovered from the latch
    assign wake_set = wake_sync & ~wake_taken_ff; // [RQ15]
    assign flag_set = edge_hit | level_hit | wake_set; // [RQ7] [RQ14] [RQ17]

    // APB decode
    assign setup = psel & ~penable;
    assign acc = psel & penable & pready_ff;
    assign hit_sc = (paddr == KWU_OFF_SC);
    assign hit_pe = (paddr == KWU_OFF_PE);
    assign hit_es = (paddr == KWU_OFF_ES);
    assign mapped = hit_sc | hit_pe | hit_es;
    assign wr_ok = acc & pwrite & pstrb[0];
    assign wr_sc = wr_ok & hit_sc;
    assign ack = wr_sc & pwdata[KWU_SC_ACK]; // [RQ10]

    assign nxt_en = (wr_ok & hit_pe) ? pwdata[NP-1:0] : en_ff; // [RQ1]
    assign nxt_pol = (wr_ok & hit_es) ? pwdata[NP-1:0] : pol_ff; // [RQ3]
    assign nxt_mode = wr_sc ? pwdata[KWU_SC_MODE] : mode_ff; // [RQ4]
    assign nxt_ie = wr_sc ? pwdata[KWU_SC_IE] : ie_ff; // [RQ9]
    // Set wins over acknowledge; written flag data is never used
    assign nxt_flag = flag_set | (flag_ff & ~ack); // [RQ10] [RQ11] [RQ12]

    // Acknowledge and upper bits read as zero
    assign sc_read = {4'h0, flag_ff, 1'b0, ie_ff, mode_ff}; // [RQ10] [RQ13]
    assign rd_byte = hit_sc ? sc_read :
                     hit_pe ? en_ff :
                     hit_es ? pol_ff : 8'h00;
    // Read data is captured in the setup cycle, on the same edge that raises ready
    assign nxt_prdata = (setup & ~pwrite) ? {24'h000000, rd_byte} : prdata_ff;
    assign nxt_state = (state_ff == KWU_APB_IDLE && setup) ? KWU_APB_ACC : KWU_APB_IDLE;

    always_ff @(posedge pclk or negedge rst_n) begin
        if (!rst_n) begin
            state_ff <= KWU_APB_IDLE;
            pready_ff <= 1'b0;
            pslverr_ff <= 1'b0;
            prdata_ff <= 32'h00000000;
        end else begin
            state_ff <= nxt_state;
            pready_ff <= (nxt_state == KWU_APB_ACC);
            pslverr_ff <= (nxt_state == KWU_APB_ACC) & ~mapped;
            prdata_ff <= nxt_prdata;
        end
    end

    always_ff @(posedge pclk or negedge rst_n) begin
        if (!rst_n) begin
            en_ff <= KWU_RST_PE; // [RQ20]
            pol_ff <= KWU_RST_ES;
            mode_ff <= KWU_RST_MODE;
            ie_ff <= KWU_RST_IE;
            flag_ff <= KWU_RST_FLAG;
        end else begin
            en_ff <= nxt_en;
            pol_ff <= nxt_pol;
            mode_ff <= nxt_mode;
            ie_ff <= nxt_ie;
            flag_ff <= nxt_flag;
        end
    end

    always_ff @(posedge pclk or negedge rst_n) begin
        if (!rst_n) begin
            armed_ff <= 1'b0; // [RQ6]
            irq_ff <= 1'b0;
            wake_taken_ff <= 1'b0;
            pullup_ff <= '0;
            pulldown_ff <= '0;
        end else begin
            armed_ff <= ~any_asserted; // [RQ6]
            irq_ff <= flag_ff & ie_ff; // [RQ9]
            wake_taken_ff <= wake_sync;
            pullup_ff <= port_pull_enable & en_ff[NUM_PINS-1:0] & ~pol_ff[NUM_PINS-1:0]; // [RQ18]
            pulldown_ff <= port_pull_enable & en_ff[NUM_PINS-1:0] & pol_ff[NUM_PINS-1:0]; // [RQ18]
        end
    end

    assign prdata = prdata_ff;
    assign pready = pready_ff;
    assign pslverr = pslverr_ff;
    assign key_irq = irq_ff;
    assign pin_pullup = pullup_ff;
    assign pin_pulldown = pulldown_ff;

    property p_no_enable_no_flag;
        @(posedge pclk) disable iff (!rst_n)
        (!flag_ff && en_ff == 8'h00 && !wake_sync) |=> !flag_ff;
    endproperty
    a_no_enable_no_flag: assert property (p_no_enable_no_flag) // [RQ1]
        else $error("flag set with all pins disabled");

    property p_edge_sets_flag;
        @(posedge pclk) disable iff (!rst_n)
        edge_hit |=> flag_ff;
    endproperty
    a_edge_sets_flag: assert property (p_edge_sets_flag) // [RQ7]
        else $error("edge did not set flag");

    property p_no_rearm;
        @(posedge pclk) disable iff (!rst_n)
        (!mode_ff && !wake_set && !flag_ff && $past(any_asserted)) |=> !flag_ff;
    endproperty
    a_no_rearm: assert property (p_no_rearm) // [RQ6]
        else $error("edge taken while a pin stayed asserted");

    property p_level_sets_flag;
        @(posedge pclk) disable iff (!rst_n)
        (mode_ff && any_asserted) |=> flag_ff;
    endproperty
    a_level_sets_flag: assert property (p_level_sets_flag) // [RQ8]
        else $error("held level did not set flag");

    property p_irq_gate;
        @(posedge pclk) disable iff (!rst_n)
        ##1 (key_irq == ($past(flag_ff) && $past(ie_ff)));
    endproperty
    a_irq_gate: assert property (p_irq_gate) // [RQ9]
        else $error("request not gated by flag and enable");

    property p_ack_clears;
        @(posedge pclk) disable iff (!rst_n)
        (ack && !flag_set) |=> !flag_ff;
    endproperty
    a_ack_clears: assert property (p_ack_clears) // [RQ10]
        else $error("acknowledge did not clear flag");

    property p_ack_held_level;
        @(posedge pclk) disable iff (!rst_n)
        (ack && mode_ff && any_asserted) |=> flag_ff;
    endproperty
    a_ack_held_level: assert property (p_ack_held_level) // [RQ11]
        else $error("flag cleared while pin asserted in level mode");

    property p_flag_write_ignored;
        @(posedge pclk) disable iff (!rst_n)
        (wr_sc && pwdata[KWU_SC_FLAG] && !flag_ff && !flag_set) |=> !flag_ff;
    endproperty
    a_flag_write_ignored: assert property (p_flag_write_ignored) // [RQ12]
        else $error("direct write changed flag");

    property p_sc_read_zero;
        @(posedge pclk) disable iff (!rst_n)
        (setup && !pwrite && hit_sc) |=> (prdata[7:4] == 4'h0 && prdata[2] == 1'b0);
    endproperty
    a_sc_read_zero: assert property (p_sc_read_zero) // [RQ13]
        else $error("unused or acknowledge bits read nonzero");

    property p_stop12_reset;
        @(posedge pclk) disable iff (!presetn)
        stop12_mode |-> ##1 (en_ff == 8'h00 && !key_irq && !flag_ff);
    endproperty
    a_stop12_reset: assert property (p_stop12_reset) // [RQ16]
        else $error("unit not reset in deep stop");

    property p_pull_dir;
        @(posedge pclk) disable iff (!rst_n)
        ##1 (pin_pullup & pin_pulldown) == '0;
    endproperty
    a_pull_dir: assert property (p_pull_dir) // [RQ18]
        else $error("pullup and pulldown both selected");

    property p_apb_ready;
        @(posedge pclk) disable iff (!rst_n)
        (setup && state_ff == KWU_APB_IDLE) |=> pready ##1 !pready;
    endproperty
    a_apb_ready: assert property (p_apb_ready)
        else $error("ready not a single access cycle");

    property p_flag_sticky;
        @(posedge pclk) disable iff (!rst_n)
        (flag_ff && !ack) |=> flag_ff;
    endproperty
    a_flag_sticky: assert property (p_flag_sticky) // [RQ7]
        else $error("flag dropped without acknowledge");

    // Hit can only rise while the enable is set between two edges
    property p_wake_gate;
        @(posedge pclk) disable iff (!rst_n)
        (!wake_req && !ie_ff && !nxt_ie) |=> !wake_req;
    endproperty
    a_wake_gate: assert property (p_wake_gate) // [RQ15]
        else $error("wake request raised with interrupt enable clear");

    property p_unmapped_ignored;
        @(posedge pclk) disable iff (!rst_n)
        (wr_ok && !mapped) |=> ($stable(en_ff) && $stable(pol_ff)
            && $stable(ie_ff) && $stable(mode_ff));
    endproperty
    a_unmapped_ignored: assert property (p_unmapped_ignored)
        else $error("write to unmapped address changed a register");

    property p_err_unmapped;
        @(posedge pclk) disable iff (!rst_n)
        (setup && state_ff == KWU_APB_IDLE) |=> (pready && pslverr == !mapped);
    endproperty
    a_err_unmapped: assert property (p_err_unmapped)
        else $error("error response does not match address decode");
endmodule : kwu_top
`default_nettype wire

// ===== tb/kwu_key_model.sv
`timescale 1ns/1ps
`default_nettype none
module kwu_key_model (
    input wire logic [3:0] press, // Switch closed per pin
    input wire logic [3:0] pol, // Asserted level per pin
    output logic [3:0] pins // Pin levels seen by the unit
);
    // An open switch rests at the level its pull resistor gives, the inverse of asserted
    assign pins = ~(pol ^ press);
endmodule : kwu_key_model
`default_nettype wire

// ===== tb/test_keyboard_pin_interrupt.sv
`timescale 1ns/1ps
`default_nettype none
module test_keyboard_pin_interrupt;
    import kwu_pkg::*;
    localparam logic [KWU_AW-1:0] SC = KWU_OFF_SC;
    localparam logic [KWU_AW-1:0] PE = KWU_OFF_PE;
    localparam logic [KWU_AW-1:0] ES = KWU_OFF_ES;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic stop3_mode = 1'b0;
    logic stop12_mode = 1'b0;
    logic [KWU_AW-1:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [3:0] pstrb = 4'hf;
    logic [3:0] press = 4'h0;
    logic [3:0] pol = 4'h0;
    logic [3:0] port_pull_enable = 4'hf;
    logic [3:0] key_input_pin, pin_pullup, pin_pulldown;
    logic [31:0] prdata;
    logic pready, pslverr, key_irq, wake_req;
    logic [15:0] lfsr = 16'hbfff;
    logic [7:0] d;
    logic [44:0] notes[$];
    logic [44:0] note;
    int errors = 0;
    int checks_done = 0;

    always #12.5 pclk = ~pclk;

    kwu_top #(.NUM_PINS(4)) kwu_top_inst (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
        .pwdata, .pstrb, .prdata, .pready, .pslverr, .key_input_pin, .port_pull_enable,
        .stop3_mode, .stop12_mode, .key_irq, .wake_req, .pin_pullup, .pin_pulldown);
    kwu_key_model kwu_key_model_inst (.press, .pol, .pins(key_input_pin));

    function automatic logic [15:0] step(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction : step

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        checks_done++;
        if (got !== exp) begin
            errors++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    // Upper data bits carry noise: only byte 0 may matter
    task automatic apb(input logic wr, input logic [KWU_AW-1:0] a, input logic [7:0] v);
        lfsr = step(lfsr);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= {lfsr, 8'h00, v};
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1)
            @(posedge pclk);
        // Only an address with no register behind it may answer with an error
        if (wr)
            chk("pslverr", {31'h0, (a != SC && a != PE && a != ES)}, {31'h0, pslverr});
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic wr(input logic [KWU_AW-1:0] a, input logic [7:0] v);
        apb(1'b1, a, v);
    endtask : wr

    task automatic rd(input logic [KWU_AW-1:0] a, input logic [7:0] v, input logic e = 1'b0);
        notes.push_back({a, e, 24'h0, v});
        apb(1'b0, a, 8'h00);
    endtask : rd

    task automatic hold(input logic [3:0] p);
        @(posedge pclk);
        press <= p;
        repeat (10) @(posedge pclk);
    endtask : hold

    task automatic late;
        repeat (2) @(posedge pclk);
        @(negedge pclk);
    endtask : late

    task automatic summarize;
        $display("checks %0d errors %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : summarize

    // Read results are judged mid-cycle, where they have settled
    always @(negedge pclk) begin
        if (psel === 1'b1 && penable === 1'b1 && pready === 1'b1 && pwrite === 1'b0) begin
            note = notes.pop_front();
            chk($sformatf("read %h", note[44:33]), note[31:0], prdata);
            chk("pslverr", {31'h0, note[32]}, {31'h0, pslverr});
        end
    end

    initial begin
        repeat (20000) @(posedge pclk);
        errors++;
        $display("Error watchdog expected done seen hang");
        summarize;
    end

    initial begin
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        rd(SC, 8'h00);
        rd(PE, KWU_RST_PE);
        rd(ES, KWU_RST_ES);
        rd(12'h00c, 8'h00, 1'b1);
        $display("test reset done");
        for (int i = 0; i < 4; i++) begin
            lfsr = step(lfsr);
            d = lfsr[7:0];
            wr(ES, d);
            rd(ES, d);
            wr(PE, ~d);
            rd(PE, ~d);
        end
        wr(PE, 8'h00);
        wr(SC, 8'hff);
        rd(SC, 8'h03);
        pstrb <= 4'h0;
        wr(SC, 8'h00);
        pstrb <= 4'hf;
        wr(12'h00c, 8'h00);
        rd(SC, 8'h03);
        $display("test registers done");
        for (int p = 0; p < 2; p++) begin
            pol <= {4{p[0]}};
            port_pull_enable <= p[0] ? 4'h1 : 4'hf;
            wr(SC, 8'h00);
            wr(ES, {8{p[0]}});
            wr(PE, 8'h03);
            wr(SC, 8'h04);
            wr(SC, 8'h02);
            late;
            chk("pin_pullup", {30'h0, {2{~p[0]}}}, {28'h0, pin_pullup});
            chk("pin_pulldown", {31'h0, p[0]}, {28'h0, pin_pulldown});
            hold(4'h4);
            rd(SC, 8'h02);
            hold(4'h5);
            rd(SC, 8'h0a);
            late;
            chk("key_irq", 32'h1, {31'h0, key_irq});
            wr(SC, 8'h06);
            rd(SC, 8'h02);
            hold(4'h7);
            rd(SC, 8'h02);
            hold(4'h0);
            hold(4'h2);
            rd(SC, 8'h0a);
            wr(SC, 8'h00);
            late;
            chk("key_irq", 32'h0, {31'h0, key_irq});
            rd(SC, 8'h08);
            hold(4'h0);
            wr(SC, 8'h04);
        end
        $display("test edge mode done");
        pol <= 4'h0;
        wr(SC, 8'h00);
        wr(ES, 8'h00);
        wr(PE, 8'h01);
        wr(SC, 8'h04);
        wr(SC, 8'h03);
        hold(4'h1);
        wr(SC, 8'h07);
        rd(SC, 8'h0b);
        hold(4'h0);
        wr(SC, 8'h07);
        rd(SC, 8'h03);
        $display("test level mode done");
        wr(SC, 8'h02);
        stop3_mode <= 1'b1;
        @(posedge pclk);
        press <= 4'h1;
        #2;
        chk("wake_req", 32'h1, {31'h0, wake_req});
        @(posedge pclk);
        stop3_mode <= 1'b0;
        hold(4'h0);
        rd(SC, 8'h0a);
        late;
        chk("wake_req", 32'h0, {31'h0, wake_req});
        $display("test stop3 done");
        @(posedge pclk);
        stop12_mode <= 1'b1;
        repeat (2) @(posedge pclk);
        stop12_mode <= 1'b0;
        rd(SC, 8'h00);
        rd(PE, 8'h00);
        rd(ES, 8'h00);
        late;
        chk("key_irq", 32'h0, {31'h0, key_irq});
        $display("test stop12 done");
        summarize;
    end
endmodule : test_keyboard_pin_interrupt
`default_nettype wire
